// [pcht_pkg.sv]
// Package: offsets, reset values and carriers for the config header tail
package pcht_pkg;
  // Configuration byte offsets
  localparam logic [7:0] OFS_SUBSYS_VENDOR = 8'h2C;
  localparam logic [7:0] OFS_SUBSYS = 8'h2E;
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_INT_ROUTE = 8'h3C;
  localparam logic [7:0] OFS_INT_PIN = 8'h3D;
  localparam logic [7:0] OFS_MIN_GNT = 8'h3E;
  localparam logic [7:0] OFS_MAX_LAT = 8'h3F;
  localparam logic [7:0] OFS_TRDY_TMO = 8'h40;
  localparam logic [7:0] OFS_RETRY_LIM = 8'h41;
  localparam logic [7:0] OFS_BUS_REL = 8'h60;
  localparam logic [7:0] OFS_FRAME_ADJ = 8'h61;
  localparam logic [7:0] OFS_PORT_WAKE = 8'h62;
  // Fixed and reset values
  localparam logic [7:0] CAP_PTR_VAL = 8'hDC;
  localparam logic [7:0] INT_PIN_VAL = 8'h01;
  localparam logic [7:0] INT_ROUTE_RST = 8'h00;
  localparam logic [7:0] TRDY_TMO_RST = 8'h00;
  localparam logic [7:0] RETRY_LIM_RST = 8'h00;
  localparam logic [7:0] MIN_GNT_OPEN = 8'h01;
  localparam logic [7:0] MIN_GNT_ENH = 8'h02;
  localparam logic [7:0] MAX_LAT_OPEN = 8'h2A;
  localparam logic [7:0] MAX_LAT_ENH = 8'h10;
  localparam logic [7:0] BUS_REL_VAL = 8'h20;
  localparam logic [7:0] FRAME_ADJ_RST = 8'h20;
  localparam logic [15:0] PORT_WAKE_RST = 16'h0007;
  // Target-ready limit layout
  localparam int TRDY_LIM_W = 13;
  localparam int TRDY_ZERO_BITS = 5;
  // Config access carrier
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] dword;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcht_req_t;
  // Transfer monitor carrier
  typedef struct packed {
    logic trdy_wait;
    logic xfer_start;
    logic retry;
  } pcht_mon_t;
endpackage

// [pcht_header_tail.sv]
// Config header tail registers of one host controller function
`timescale 1ns/1ps
`default_nettype none
module pcht_header_tail #(
  parameter bit ENHANCED = 1'b0,
  parameter logic [15:0] SUBSYS_VENDOR = 16'hA5A5, // Arbitrary value
  parameter logic [15:0] SUBSYS_OPEN = 16'h5A01, // Arbitrary value
  parameter logic [15:0] SUBSYS_ENH = 16'h5A02 // Arbitrary value
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Configuration access
  input wire pcht_pkg::pcht_req_t CFG_REQ,
  output logic [31:0] CFG_RDATA,
  output logic CFG_ACK,
  // Transfer monitor from this function's master logic
  input wire pcht_pkg::pcht_mon_t MON,
  // Error flag toward the status word
  input wire logic UE_CLEAR,
  output logic UNRECOVERABLE_ERROR_FLAG,
  // Setting seen by the frame timer
  output logic [5:0] FRAME_LENGTH_ADJUST
);
  localparam int LW = pcht_pkg::TRDY_LIM_W;
  logic [7:0] int_route_q, int_route_d;
  logic [7:0] trdy_tmo_q, trdy_tmo_d;
  logic [7:0] retry_lim_q, retry_lim_d;
  logic [7:0] frame_adj_q, frame_adj_d;
  logic [15:0] port_wake_q, port_wake_d;
  logic [LW-1:0] trdy_cnt_q, trdy_cnt_d;
  logic [7:0] retry_cnt_q, retry_cnt_d;
  logic ue_q, ue_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic [LW-1:0] trdy_limit;
  logic trdy_over, retry_over;

  // Byte-lane merge for a writable byte
  function automatic logic [7:0] lane(input logic [7:0] old,
      input logic [31:0] wd, input logic [3:0] be, input int idx);
    lane = be[idx] ? wd[idx*8 +: 8] : old;
  endfunction

  // Dword hit test on a byte offset
  function automatic logic hit(input logic [5:0] dw, input logic [7:0] ofs);
    hit = (dw == ofs[7:2]);
  endfunction

  // Limit is the byte with five zero bits below it
  assign trdy_limit = {trdy_tmo_q, {pcht_pkg::TRDY_ZERO_BITS{1'b0}}};
  assign trdy_over = (trdy_tmo_q != 8'h00) && MON.trdy_wait
                     && (trdy_cnt_q >= trdy_limit);
  assign retry_over = (retry_lim_q != 8'h00) && MON.retry
                      && (retry_cnt_q >= retry_lim_q);

  // Writable bytes; read-only bytes have no storage, so writes drop
  always_comb begin
    int_route_d = int_route_q;
    trdy_tmo_d = trdy_tmo_q;
    retry_lim_d = retry_lim_q;
    frame_adj_d = frame_adj_q;
    port_wake_d = port_wake_q;
    if (CFG_REQ.wr) begin
      if (hit(CFG_REQ.dword, pcht_pkg::OFS_INT_ROUTE)) begin
        int_route_d = lane(int_route_q, CFG_REQ.wdata, CFG_REQ.be, 0);
      end
      if (hit(CFG_REQ.dword, pcht_pkg::OFS_TRDY_TMO)) begin
        trdy_tmo_d = lane(trdy_tmo_q, CFG_REQ.wdata, CFG_REQ.be, 0);
        retry_lim_d = lane(retry_lim_q, CFG_REQ.wdata, CFG_REQ.be, 1);
      end
      if (ENHANCED && hit(CFG_REQ.dword, pcht_pkg::OFS_BUS_REL)) begin
        frame_adj_d = lane(frame_adj_q, CFG_REQ.wdata, CFG_REQ.be, 1);
        port_wake_d[7:0] = lane(port_wake_q[7:0], CFG_REQ.wdata, CFG_REQ.be, 2);
        port_wake_d[15:8] = lane(port_wake_q[15:8], CFG_REQ.wdata, CFG_REQ.be, 3);
      end
    end
  end

  // Wait and retry counters; the error flag set wins over a clear
  always_comb begin
    trdy_cnt_d = trdy_cnt_q;
    retry_cnt_d = retry_cnt_q;
    ue_d = ue_q;
    if (!MON.trdy_wait) begin
      trdy_cnt_d = '0;
    end else if (trdy_cnt_q != {LW{1'b1}}) begin
      trdy_cnt_d = trdy_cnt_q + 1'b1;
    end
    // Retry count restarts per transfer and saturates
    if (MON.xfer_start) begin
      retry_cnt_d = '0;
    end else if (MON.retry && retry_cnt_q != 8'hFF) begin
      retry_cnt_d = retry_cnt_q + 8'h01;
    end
    if (UE_CLEAR) begin
      ue_d = 1'b0;
    end
    if (trdy_over || retry_over) begin
      ue_d = 1'b1;
    end
  end

  // Read mux; answers one cycle after the request
  always_comb begin
    rdata_d = 32'h0000_0000;
    ack_d = CFG_REQ.rd || CFG_REQ.wr;
    if (CFG_REQ.rd) begin
      if (hit(CFG_REQ.dword, pcht_pkg::OFS_SUBSYS_VENDOR)) begin
        rdata_d = {ENHANCED ? SUBSYS_ENH : SUBSYS_OPEN,
                   SUBSYS_VENDOR};
      end else if (hit(CFG_REQ.dword, pcht_pkg::OFS_CAP_PTR)) begin
        // Low two bits forced so the pointer is always dword aligned
        rdata_d = {24'h000000, pcht_pkg::CAP_PTR_VAL[7:2], 2'b00};
      end else if (hit(CFG_REQ.dword, pcht_pkg::OFS_INT_ROUTE)) begin
        // Grant and latency in 250 ns units; pin is INTA encoding
        rdata_d = {ENHANCED ? pcht_pkg::MAX_LAT_ENH
                            : pcht_pkg::MAX_LAT_OPEN,
                   ENHANCED ? pcht_pkg::MIN_GNT_ENH
                            : pcht_pkg::MIN_GNT_OPEN,
                   pcht_pkg::INT_PIN_VAL,
                   int_route_q};
      end else if (hit(CFG_REQ.dword, pcht_pkg::OFS_TRDY_TMO)) begin
        rdata_d = {16'h0000, retry_lim_q, trdy_tmo_q};
      end else if (ENHANCED && hit(CFG_REQ.dword, pcht_pkg::OFS_BUS_REL)) begin
        rdata_d = {port_wake_q, frame_adj_q, pcht_pkg::BUS_REL_VAL};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      int_route_q <= pcht_pkg::INT_ROUTE_RST;
      trdy_tmo_q <= pcht_pkg::TRDY_TMO_RST;
      retry_lim_q <= pcht_pkg::RETRY_LIM_RST;
      frame_adj_q <= pcht_pkg::FRAME_ADJ_RST;
      port_wake_q <= pcht_pkg::PORT_WAKE_RST;
      trdy_cnt_q <= '0;
      retry_cnt_q <= 8'h00;
      ue_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      int_route_q <= int_route_d;
      trdy_tmo_q <= trdy_tmo_d;
      retry_lim_q <= retry_lim_d;
      frame_adj_q <= frame_adj_d;
      port_wake_q <= port_wake_d;
      trdy_cnt_q <= trdy_cnt_d;
      retry_cnt_q <= retry_cnt_d;
      ue_q <= ue_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign CFG_RDATA = rdata_q;
  assign CFG_ACK = ack_q;
  assign UNRECOVERABLE_ERROR_FLAG = ue_q;
  assign FRAME_LENGTH_ADJUST = frame_adj_q[5:0];
endmodule
`default_nettype wire

// [pcht_host.sv]
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module pcht_host (
  // Clock
  input wire logic clk,
  // Access toward the function
  output pcht_pkg::pcht_req_t req,
  input wire logic [31:0] rdata,
  input wire logic ack
);
  logic [31:0] got;
  logic got_ack;
  initial req = '0;
  // Never follows the pointer, so masking and flag use hold
  task automatic cfg(input logic w, input logic [5:0] d,
                     input logic [3:0] be, input logic [31:0] wd);
    @(negedge clk);
    req = {~w, w, d, be, wd};
    @(negedge clk);
    got = rdata;
    got_ack = ack;
    req = '0;
  endtask
endmodule
`default_nettype wire

// [pcht_chk.sv]
// Checker for the config header tail ports
`timescale 1ns/1ps
`default_nettype none
module pcht_chk #(parameter bit ENHANCED = 1'b0) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Access, monitor and flag
  input wire pcht_pkg::pcht_req_t CFG_REQ,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_ACK,
  input wire pcht_pkg::pcht_mon_t MON,
  input wire logic UE_CLEAR,
  input wire logic UNRECOVERABLE_ERROR_FLAG,
  input wire logic [5:0] FRAME_LENGTH_ADJUST
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence rd_of(d);
    CFG_REQ.rd && CFG_REQ.dword == d;
  endsequence
  a_ack_follows: assert property ((CFG_REQ.rd || CFG_REQ.wr) |=> CFG_ACK)
    else $error("access not acked");
  a_cap_ptr: assert property (rd_of(6'h0D) |=> CFG_RDATA == 32'hDC)
    else $error("capability pointer wrong");
  a_pin_byte: assert property (rd_of(6'h0F) |=> CFG_RDATA[15:8] == 8'h01)
    else $error("interrupt pin wrong");
  a_grant_lat: assert property (rd_of(6'h0F) |=> CFG_RDATA[31:16] ==
    (ENHANCED ? 16'h1002 : 16'h2A01)) else $error("grant or latency wrong");
  a_unmapped_zero: assert property (rd_of(6'h20) |=> CFG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_adj_echo: assert property (rd_of(6'h18) |=> !ENHANCED ||
    CFG_RDATA[13:8] == FRAME_LENGTH_ADJUST) else $error("adjust mismatch");
  a_flag_holds: assert property (UNRECOVERABLE_ERROR_FLAG && !UE_CLEAR |=>
    UNRECOVERABLE_ERROR_FLAG) else $error("error flag dropped");
  a_flag_cause: assert property ($rose(UNRECOVERABLE_ERROR_FLAG) |->
    $past(MON.trdy_wait || MON.retry)) else $error("error flag uncaused");
endmodule
bind pcht_header_tail pcht_chk #(.ENHANCED(ENHANCED)) pcht_chk_i (.CLK(CLK),
  .RST(RST), .CFG_REQ(CFG_REQ), .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK),
  .MON(MON), .UE_CLEAR(UE_CLEAR),
  .UNRECOVERABLE_ERROR_FLAG(UNRECOVERABLE_ERROR_FLAG),
  .FRAME_LENGTH_ADJUST(FRAME_LENGTH_ADJUST));
`default_nettype wire

// [tb_pcht_header_tail.sv]
// Testbench for the config header tail, enhanced function
`timescale 1ns/1ps
`default_nettype none
module tb_pcht_header_tail;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic clr = 1'b0;
  logic ack, ue;
  logic [31:0] rdata;
  logic [5:0] fla;
  pcht_pkg::pcht_req_t req;
  pcht_pkg::pcht_mon_t mon = '0;
  int mismatches = 0, comparisons = 0, cyc = 0;
  initial forever #12.5 CLK = ~CLK;
  pcht_host pcht_host_i (.clk(CLK), .req(req), .rdata(rdata), .ack(ack));
  // Identity values are arbitrary
  pcht_header_tail #(.ENHANCED(1'b1), .SUBSYS_VENDOR(16'hC0DE),
    .SUBSYS_ENH(16'h0E02)) pcht_header_tail_i (.CLK(CLK), .RST(RST),
    .CFG_REQ(req), .CFG_RDATA(rdata), .CFG_ACK(ack), .MON(mon),
    .UE_CLEAR(clr), .UNRECOVERABLE_ERROR_FLAG(ue),
    .FRAME_LENGTH_ADJUST(fla));
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: data %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] d, input logic [31:0] exp);
    pcht_host_i.cfg(1'b0, d, 4'hF, 32'h0);
    chk_flag(pcht_host_i.got_ack, 1'b1);
    chk(pcht_host_i.got, exp);
  endtask
  task automatic wr(input logic [5:0] d, input logic [3:0] be,
                    input logic [31:0] wd);
    pcht_host_i.cfg(1'b1, d, be, wd);
    chk_flag(pcht_host_i.got_ack, 1'b1);
  endtask
  // Hold a target-ready wait for n cycles, then let the flag settle
  task automatic hold_wait(input int n, input logic exp);
    @(negedge CLK) mon.trdy_wait = 1'b1;
    repeat (n) @(negedge CLK);
    mon.trdy_wait = 1'b0;
    repeat (2) @(negedge CLK);
    chk_flag(ue, exp);
  endtask
  task automatic pulse(input logic x, r, exp);
    @(negedge CLK) mon = {1'b0, x, r};
    @(negedge CLK) mon = '0;
    @(negedge CLK) chk_flag(ue, exp);
  endtask
  task automatic clear_flag;
    @(negedge CLK) clr = 1'b1;
    @(negedge CLK) clr = 1'b0;
    @(negedge CLK) chk_flag(ue, 1'b0);
  endtask
  task automatic t_ident;
    rd(6'h0B, 32'h0E02C0DE);
    rd(6'h0D, 32'h000000DC);
    rd(6'h0F, 32'h10020100);
    rd(6'h10, 32'h0);
    rd(6'h18, 32'h00072020);
    rd(6'h20, 32'h0);
    chk({26'h0, fla}, 32'h00000020);
    $display("ident done");
  endtask
  task automatic t_ro;
    wr(6'h0B, 4'hF, 32'hFFFFFFFF);
    wr(6'h0D, 4'hF, 32'hFFFFFFFF);
    wr(6'h0F, 4'hE, 32'hFFFFFFFF);
    rd(6'h0B, 32'h0E02C0DE);
    rd(6'h0D, 32'h000000DC);
    rd(6'h0F, 32'h10020100);
    $display("read-only done");
  endtask
  task automatic t_rw;
    wr(6'h0F, 4'h1, 32'hFFFFFFA5);
    wr(6'h10, 4'h3, 32'h00000201);
    rd(6'h0F, 32'h100201A5);
    rd(6'h10, 32'h00000201);
    $display("read-write done");
  endtask
  // Limit is 32 cycles with the timeout byte at 1
  task automatic t_trdy;
    hold_wait(20, 1'b0);
    hold_wait(40, 1'b1);
    clear_flag;
    $display("target-ready done");
  endtask
  task automatic t_retry;
    wr(6'h10, 4'h1, 32'h0);
    hold_wait(60, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    pulse(1'b0, 1'b1, 1'b0);
    pulse(1'b0, 1'b1, 1'b0);
    pulse(1'b0, 1'b1, 1'b1);
    clear_flag;
    $display("retry done");
  endtask
  // Writable bytes of the enhanced block read back; the frame adjust byte reaches the frame timer output
  task automatic t_enh;
    wr(6'h18, 4'hE, 32'h12343F55);
    rd(6'h18, 32'h12343F20);
    chk({26'h0, fla}, 32'h0000003F);
    $display("enhanced done");
  endtask
  // Mid-run reset must drop the flag and restore every writable byte
  task automatic t_reset;
    pulse(1'b0, 1'b1, 1'b1);
    @(negedge CLK) RST = 1'b1;
    repeat (2) @(negedge CLK);
    RST = 1'b0;
    chk_flag(ue, 1'b0);
    chk({26'h0, fla}, 32'h00000020);
    rd(6'h0F, 32'h10020100);
    rd(6'h10, 32'h0);
    rd(6'h18, 32'h00072020);
    $display("reset done");
  endtask
  task automatic close_out;
    $display("compared %0d, mismatched %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      close_out;
    end
  end
  initial begin
    repeat (6) @(negedge CLK);
    RST = 1'b0;
    t_ident;
    t_ro;
    t_rw;
    t_trdy;
    t_retry;
    t_enh;
    t_reset;
    close_out;
  end
endmodule
`default_nettype wire
